// ### core/sarcs_sequencer.v
/*
 Successive-approximation conversion sequencer for a 12-bit
 converter: trigger handling, bit trials, busy flag, parallel and
 serial result, short-cycle truncation.
 Assumes the comparator and short-cycle inputs are synchronous
 digital levels; short_cycle_i is tied low for full conversions.
*/
`timescale 1ns/10ps
`include "sarcs_defines.vh"

// Function
// - A full conversion runs twelve trials starting at half scale.
// - First decision sets the top bit if input exceeds trial, else clears.
// - Each later trial steps by the next binary weight; decisions clocked in.
// - Trigger pulse resets trial to half scale and raises busy.
// - Conversion clock starts and trials begin on trigger falling edge.
// - Busy falls after the final trial; parallel result then valid.
// - Truncation input tied to a result bit ends conversion early.
// - Result code is straight binary.
// - Result available in parallel and serially, internal or external clock.
// - Internal clock gives about 5.8 us per full conversion.
// - Fast trim completes a full conversion in 3.0 us.
module sarcs_sequencer #(
    parameter STD_CYC = `SARCS_STD_BIT_CYC,
    parameter FAST_CYC = `SARCS_FAST_BIT_CYC
)
(
    input wire clock_i,
    input wire rst_n_i,
    input wire convert_start_i,
    input wire comparator_i,
    input wire short_cycle_i,
    input wire ext_clk_sel_i,
    input wire ext_conv_clk_i,
    input wire fast_trim_i,
    output wire [11:0] parallel_result_bits_o,
    output wire serial_result_output_o,
    output wire busy_o,
    output wire conv_clk_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [11:0] approximation_register_reg;
    reg [11:0] approximation_register_next;
    reg [3:0] idx_reg;
    reg [3:0] idx_next;
    reg busy_reg;
    reg busy_next;
    reg run_reg;
    reg run_next;
    reg serial_reg;
    reg serial_next;
    wire step;

    localparam [1:0] ST_IDLE = `SARCS_ST_IDLE;
    localparam [1:0] ST_ARMED = `SARCS_ST_ARMED;
    localparam [1:0] ST_CONV = `SARCS_ST_CONV;

    // ----------------------------------------------------------------
    // Trial code update
    // ----------------------------------------------------------------
    function [11:0] sarcs_decide;
        input [11:0] code;
        input [3:0] idx;
        input decision;
        reg [11:0] mask;
        begin
            mask = 12'h001 << idx;
            if (decision)
                sarcs_decide = code | mask;
            else
                sarcs_decide = code & ~mask;
        end
    endfunction

    // ----------------------------------------------------------------
    // Conversion clock
    // ----------------------------------------------------------------
    sarcs_clkgen #(
        .STD_CYC(STD_CYC),
        .FAST_CYC(FAST_CYC)
    ) u_clkgen (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .enable_i(run_reg),
        .ext_clk_sel_i(ext_clk_sel_i),
        .ext_conv_clk_i(ext_conv_clk_i),
        .fast_trim_i(fast_trim_i),
        .conv_clk_o(conv_clk_o),
        .step_o(step)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always @*
    begin
        state_next = state_reg;
        approximation_register_next = approximation_register_reg;
        idx_next = idx_reg;
        busy_next = busy_reg;
        run_next = run_reg;
        serial_next = serial_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (convert_start_i)
                begin
                    // Trigger restarts at half scale
                    approximation_register_next = `SARCS_HALF_SCALE;
                    idx_next = `SARCS_MSB_IDX;
                    busy_next = 1'b1;
                    state_next = ST_ARMED;
                end
            end
            ST_ARMED:
            begin
                if (!convert_start_i)
                begin
                    // Trailing edge enables the clock
                    run_next = 1'b1;
                    state_next = ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (convert_start_i)
                begin
                    // Retrigger mid-conversion restarts
                    approximation_register_next = `SARCS_HALF_SCALE;
                    idx_next = `SARCS_MSB_IDX;
                    run_next = 1'b0;
                    state_next = ST_ARMED;
                end
                else if (step)
                begin
                    if (short_cycle_i && idx_reg != `SARCS_MSB_IDX)
                    begin
                        // Tied bit reached: drop its trial and stop
                        approximation_register_next =
                            sarcs_decide(approximation_register_reg, idx_reg, 1'b0);
                        busy_next = 1'b0;
                        run_next = 1'b0;
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        // Straight binary decision
                        approximation_register_next =
                            sarcs_decide(approximation_register_reg, idx_reg, comparator_i);
                        serial_next = comparator_i;
                        if (idx_reg == 4'h0)
                        begin
                            // All twelve trials done
                            busy_next = 1'b0;
                            run_next = 1'b0;
                            state_next = ST_IDLE;
                        end
                        else
                        begin
                            // Next weight set as trial
                            approximation_register_next[idx_reg - 4'h1] = 1'b1;
                            idx_next = idx_reg - 4'h1;
                        end
                    end
                end
            end
            default:
            begin
                state_next = ST_IDLE;
                busy_next = 1'b0;
                run_next = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= ST_IDLE;
            approximation_register_reg <= `SARCS_ZERO_CODE;
            idx_reg <= `SARCS_MSB_IDX;
            busy_reg <= 1'b0;
            run_reg <= 1'b0;
            serial_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            approximation_register_reg <= approximation_register_next;
            idx_reg <= idx_next;
            busy_reg <= busy_next;
            run_reg <= run_next;
            serial_reg <= serial_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign parallel_result_bits_o = approximation_register_reg;
    assign serial_result_output_o = serial_reg;
    assign busy_o = busy_reg;

endmodule // sarcs_sequencer

// ### common/sarcs_defines.vh
/*
 Constants for the successive-approximation conversion sequencer:
 code width, reset trial code and conversion timing counts.
 Assumes a 40 MHz system clock; included by bare name.
*/
`ifndef SARCS_DEFINES_VH
`define SARCS_DEFINES_VH

// ----------------------------------------------------------------
// Code layout
// ----------------------------------------------------------------
`define SARCS_NUM_BITS 12
`define SARCS_MSB_IDX 4'hb
`define SARCS_HALF_SCALE 12'h800
`define SARCS_ZERO_CODE 12'h000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SARCS_CLK_PERIOD_NS 25
`define SARCS_STD_CONV_NS 5800
`define SARCS_FAST_CONV_NS 3000
`define SARCS_STD_BIT_CYC ((`SARCS_STD_CONV_NS / `SARCS_NUM_BITS) / `SARCS_CLK_PERIOD_NS)
`define SARCS_FAST_BIT_CYC ((`SARCS_FAST_CONV_NS / `SARCS_NUM_BITS) / `SARCS_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------
`define SARCS_ST_IDLE 2'h0
`define SARCS_ST_ARMED 2'h1
`define SARCS_ST_CONV 2'h2

`endif

// ### core/sarcs_clkgen.v
/*
 Conversion clock generator: internal divider or sampled external
 clock, gated by an enable, with a one-cycle step pulse per bit.
 Assumes ext_conv_clk_i is synchronous to clock_i.
*/
`timescale 1ns/10ps
`include "sarcs_defines.vh"

module sarcs_clkgen #(
    parameter STD_CYC = `SARCS_STD_BIT_CYC,
    parameter FAST_CYC = `SARCS_FAST_BIT_CYC
)
(
    input wire clock_i,
    input wire rst_n_i,
    input wire enable_i,
    input wire ext_clk_sel_i,
    input wire ext_conv_clk_i,
    input wire fast_trim_i,
    output reg conv_clk_o,
    output reg step_o
);

    reg [7:0] cnt_reg;
    reg ext_prev_reg;
    wire [7:0] period;
    wire [7:0] half;

    assign period = fast_trim_i ? FAST_CYC[7:0] : STD_CYC[7:0];
    assign half = {1'b0, period[7:1]};

    // ----------------------------------------------------------------
    // Divider and external clock edge tracking
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= 8'h00;
            ext_prev_reg <= 1'b0;
            conv_clk_o <= 1'b0;
            step_o <= 1'b0;
        end
        else
        begin
            ext_prev_reg <= ext_conv_clk_i;
            step_o <= 1'b0;
            if (!enable_i)
            begin
                // Clock idle outside a conversion
                cnt_reg <= 8'h00;
                conv_clk_o <= 1'b0;
            end
            else if (ext_clk_sel_i)
            begin
                conv_clk_o <= ext_conv_clk_i;
                // Step on external falling edge
                if (ext_prev_reg && !ext_conv_clk_i)
                    step_o <= 1'b1;
            end
            else
            begin
                // One bit per divider period
                if (cnt_reg >= period - 8'h01)
                begin
                    cnt_reg <= 8'h00;
                    step_o <= 1'b1;
                end
                else
                    cnt_reg <= cnt_reg + 8'h01;
                conv_clk_o <= (cnt_reg < half) ? 1'b1 : 1'b0;
            end
        end
    end

endmodule // sarcs_clkgen

// ### testbench/sarcs_host_model.sv
/* Host and analogue side model: comparator, truncation tie, gated external
   clock, result capture. Assumes the sequencer's synchronous outputs. */
`timescale 1ns/10ps
module sarcs_host_model (
    input wire clock_i,
    input wire [11:0] vin_i,
    input wire trunc_i,
    input wire ext_i,
    input wire busy_i,
    input wire [11:0] res_i,
    input wire ser_i,
    output wire comp_o,
    output wire short_o,
    output reg ext_clk_o = 1'b0,
    output reg [11:0] cap_o,
    output reg [11:0] log_o
);
    reg busy_reg;
    reg [11:0] res_reg;
    reg [2:0] cnt_reg;
    assign comp_o = vin_i >= res_i;
    assign short_o = trunc_i & res_i[1];
    always @(posedge clock_i)
    begin
        busy_reg <= busy_i;
        res_reg <= res_i;
        cnt_reg <= (ext_i && busy_i && cnt_reg < 3'h5) ? cnt_reg + 3'h1 : 3'h0;
        ext_clk_o <= ext_i && busy_i && cnt_reg < 3'h3;
        if (busy_reg && !busy_i)
            cap_o <= res_i;
        if (busy_i && !busy_reg)
            log_o <= 12'h000;
        else if (busy_reg && (!busy_i || res_i !== res_reg))
            log_o <= {log_o[10:0], ser_i};
    end
endmodule // sarcs_host_model

// ### testbench/sarcs_checker.sv
/* Concurrent checks on the sequencer top ports.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/10ps
module sarcs_checker (
    input wire clock_i,
    input wire rst_n_i,
    input wire convert_start_i,
    input wire comparator_i,
    input wire short_cycle_i,
    input wire ext_clk_sel_i,
    input wire ext_conv_clk_i,
    input wire fast_trim_i,
    input wire [11:0] parallel_result_bits_o,
    input wire serial_result_output_o,
    input wire busy_o,
    input wire conv_clk_o
);
    localparam int MAX_CONV = 400;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence trig_s;
        convert_start_i ##1 !convert_start_i;
    endsequence
    sequence idle_s;
        !busy_o ##1 !busy_o;
    endsequence
    start_resets_a: assert property (convert_start_i |=> busy_o && parallel_result_bits_o == 12'h800)
        else $error("trigger did not load half scale");
    busy_cause_a: assert property ($rose(busy_o) |-> $past(convert_start_i))
        else $error("busy rose without trigger");
    conv_bound_a: assert property (trig_s |-> ##[1:MAX_CONV] !busy_o)
        else $error("conversion did not end");
    clk_idle_a: assert property (idle_s |-> !conv_clk_o)
        else $error("conversion clock runs while idle");
    armed_wait_a: assert property ($past(convert_start_i) && convert_start_i |->
        busy_o && parallel_result_bits_o == 12'h800) else $error("trials began before trigger fell");
    result_hold_a: assert property (!busy_o && !$past(busy_o) && !$past(convert_start_i) |->
        $stable(parallel_result_bits_o)) else $error("result moved while idle");
    step_weight_a: assert property (busy_o && !$past(convert_start_i) |->
        $countones(parallel_result_bits_o ^ $past(parallel_result_bits_o)) <= 2) else $error("bad trial step");
    serial_follows_a: assert property (busy_o && !$past(convert_start_i) && $changed(serial_result_output_o) |->
        $changed(parallel_result_bits_o)) else $error("serial moved without decision");
endmodule // sarcs_checker
bind sarcs_sequencer sarcs_checker i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .convert_start_i(convert_start_i),
    .comparator_i(comparator_i), .short_cycle_i(short_cycle_i), .ext_clk_sel_i(ext_clk_sel_i),
    .ext_conv_clk_i(ext_conv_clk_i), .fast_trim_i(fast_trim_i), .parallel_result_bits_o(parallel_result_bits_o),
    .serial_result_output_o(serial_result_output_o), .busy_o(busy_o), .conv_clk_o(conv_clk_o));

// ### testbench/testbench.sv
/* Self-checking bench for the conversion sequencer with a host model.
   Assumes short per-bit counts set through the sequencer parameters. */
`timescale 1ns/10ps
module testbench;
    localparam STD = 4;
    localparam FAST = 2;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg start = 1'b0;
    reg trunc = 1'b0;
    reg ext_sel = 1'b0;
    reg fast = 1'b0;
    reg [11:0] vin = 12'h000;
    wire [11:0] result, cap, ser_log;
    wire serial, busy, conv_clk, comp, short, ext_clk;
    integer fails = 0;
    integer compares = 0;
    integer n, i, cyc;
    reg [25:0] rows [0:4];
    always #12.5 clock = ~clock;
    sarcs_sequencer #(.STD_CYC(STD), .FAST_CYC(FAST)) i_dut (.clock_i(clock), .rst_n_i(rst_n),
        .convert_start_i(start), .comparator_i(comp), .short_cycle_i(short), .ext_clk_sel_i(ext_sel),
        .ext_conv_clk_i(ext_clk), .fast_trim_i(fast), .parallel_result_bits_o(result),
        .serial_result_output_o(serial), .busy_o(busy), .conv_clk_o(conv_clk));
    sarcs_host_model i_host (.clock_i(clock), .vin_i(vin), .trunc_i(trunc), .ext_i(ext_sel), .busy_i(busy),
        .res_i(result), .ser_i(serial), .comp_o(comp), .short_o(short), .ext_clk_o(ext_clk), .cap_o(cap),
        .log_o(ser_log));
    task check(input [11:0] got, input [11:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task complete_run;
    begin
        $display("mismatches %0d, comparisons %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    // Trigger held two edges, then count cycles until busy drops
    task convert(input [11:0] v);
    begin
        @(posedge clock);
        vin <= v;
        start <= 1'b1;
        repeat (2) @(posedge clock);
        start <= 1'b0;
        n = 0;
        @(posedge clock);
        #1;
        while (busy === 1'b1 && n < 500)
        begin
            @(posedge clock);
            #1;
            n = n + 1;
        end
        if (n >= 500)
            fails = fails + 1;
        repeat (2) @(posedge clock);
    end
    endtask
    task check_len(input integer lo, input integer hi);
    begin
        check({11'h000, n >= lo && n <= hi}, 12'h001);
    end
    endtask
    initial
    begin
        rows[0] = {12'h000, 1'b0, 1'b0, 12'h000};
        rows[1] = {12'h800, 1'b0, 1'b1, 12'h800};
        rows[2] = {12'hfff, 1'b0, 1'b1, 12'hfff};
        rows[3] = {12'h7ff, 1'b1, 1'b0, 12'h7ff};
        rows[4] = {12'ha5c, 1'b1, 1'b0, 12'ha5c};
        repeat (6) @(posedge clock);
        #1;
        check(result, 12'h000);
        check({9'h000, busy, serial, conv_clk}, 12'h000);
        @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i = i + 1)
        begin
            @(posedge clock);
            ext_sel <= rows[i][13];
            fast <= rows[i][12];
            cyc = rows[i][12] ? FAST : STD;
            convert(rows[i][25:14]);
            check(cap, rows[i][11:0]);
            check(ser_log, rows[i][11:0]);
            if (!rows[i][13]) check_len(12 * cyc - 1, 12 * cyc + 4);
        end
        ext_sel <= 1'b0;
        fast <= 1'b0;
        trunc <= 1'b1;
        convert(12'hfff);
        check(cap, 12'hffc);
        check_len(10 * STD - 1, 11 * STD + 4);
        ext_sel <= 1'b1;
        convert(12'h5a7);
        check(cap, 12'h5a4);
        trunc <= 1'b0;
        ext_sel <= 1'b0;
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        repeat (20) @(posedge clock);
        convert(12'h3c1);
        check(cap, 12'h3c1);
        check_len(12 * STD - 1, 12 * STD + 4);
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b0;
        @(posedge clock);
        #1;
        check(result, 12'h000);
        check({9'h000, busy, serial, conv_clk}, 12'h000);
        @(posedge clock);
        rst_n <= 1'b1;
        convert(12'h001);
        check(cap, 12'h001);
        complete_run;
    end
    initial
    begin
        #100000;
        fails = fails + 1;
        complete_run;
    end
endmodule // testbench
